// >>> bslr_pkg.sv
package bslr_pkg;

  // register offsets on the control port
  localparam logic [7:0] OFF_CONV2_LIMIT = 8'h09;
  localparam logic [7:0] OFF_CONV3_OP    = 8'h0a;
  localparam logic [7:0] OFF_CONV3_ALT   = 8'h0b;
  localparam logic [7:0] OFF_CONV3_LIMIT = 8'h0c;
  localparam logic [7:0] OFF_CONV4_OP    = 8'h0d;
  localparam logic [7:0] OFF_CONV4_ALT   = 8'h0e;
  localparam logic [7:0] OFF_CONV4_LIMIT = 8'h0f;

  // field positions
  localparam int BIT_RESERVED   = 7;
  localparam int BIT_SRC_SELECT = 6;
  localparam int BIT_ENABLE     = 7;
  localparam int BIT_LIGHT_LOAD = 6;
  localparam int CODE_MSB       = 5;
  localparam int RANGE_MSB      = 7;
  localparam int RANGE_LSB      = 6;

  // maximum-code values that leave the limit register writable
  localparam logic [5:0] MAX_NO_LIMIT = 6'h3f;
  localparam logic [5:0] MAX_UNSET    = 6'h00;

  // output voltage in 0.5 mV units
  localparam logic [12:0] VBASE_500MV = 13'h03e8;
  localparam logic [12:0] VBASE_700MV = 13'h0578;
  localparam logic [12:0] STEP_12M5   = 13'h0019;
  localparam logic [12:0] STEP_25M    = 13'h0032;
  localparam logic [12:0] STEP_50M    = 13'h0064;

  typedef enum logic [1:0] {
    BSLR_REG_OP    = 2'b00,
    BSLR_REG_ALT   = 2'b01,
    BSLR_REG_LIMIT = 2'b10
  } bslr_reg_t;

  typedef struct packed {
    logic       en;
    logic [5:0] op_code;
    logic [5:0] alt_code;
    logic [1:0] range;
    logic [5:0] max_code;
  } bslr_otp_t;

  typedef struct packed {
    logic       src_sel;
    logic [5:0] op_code;
    logic       en;
    logic       light;
    logic [5:0] alt_code;
    logic [1:0] range;
    logic [5:0] max_code;
  } bslr_chan_t;

  typedef struct packed {
    logic        on;
    logic        light;
    logic [1:0]  range;
    logic [5:0]  code;
    logic [12:0] vout;
  } bslr_drive_t;

  typedef struct packed {
    logic       hit;
    logic [1:0] chan;
    bslr_reg_t  kind;
  } bslr_dec_t;

  typedef struct packed {
    logic [7:0]       rdata;
    bslr_drive_t [2:0] drive;
  } bslr_top_t;

  function automatic logic limit_locked(input logic [5:0] max_code);
    return (max_code != MAX_NO_LIMIT) && (max_code != MAX_UNSET);
  endfunction

  // a zero maximum means no limit has been programmed
  function automatic logic [5:0] clamp_code(input logic [5:0] code, input logic [5:0] max_code);
    return ((max_code != MAX_UNSET) && (code > max_code)) ? max_code : code;
  endfunction

  function automatic logic [12:0] code_to_vout(input logic [1:0] range, input logic [5:0] code);
    logic [12:0] c;
    c = {7'h00, code};
    unique case (range)
      2'b00: return 13'(VBASE_500MV + c * STEP_12M5);
      2'b01: return 13'(VBASE_700MV + c * STEP_12M5);
      2'b10: return 13'(VBASE_500MV + c * STEP_25M);
      2'b11: return 13'(VBASE_500MV + c * STEP_50M);
    endcase
  endfunction

endpackage

// >>> bslr_chan.sv
`timescale 1ns/10ps
module bslr_chan #(
  parameter bit HAS_SETPT = 1'b1
) (
  // clock and power-on reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // programmed defaults
  input  wire logic                  otp_reload_i,
  input  wire bslr_pkg::bslr_otp_t   otp_i,
  // register writes
  input  wire logic                  wr_i,
  input  wire bslr_pkg::bslr_reg_t   wsel_i,
  input  wire logic [7:0]            wdata_i,
  // stored contents
  output bslr_pkg::bslr_chan_t       chan_o
);

  bslr_pkg::bslr_chan_t q, d;
  bslr_pkg::bslr_chan_t otp_state;

  always_comb begin
    otp_state          = '0;
    otp_state.op_code  = otp_i.op_code;
    otp_state.en       = otp_i.en;
    otp_state.alt_code = otp_i.alt_code;
    otp_state.range    = otp_i.range;
    otp_state.max_code = otp_i.max_code;
    d = q;
    if (wr_i) begin
      unique case (wsel_i)
        bslr_pkg::BSLR_REG_OP: begin
          if (HAS_SETPT) begin
            // the reserved bit is never stored
            d.src_sel = wdata_i[bslr_pkg::BIT_SRC_SELECT];
            d.op_code = bslr_pkg::clamp_code(wdata_i[bslr_pkg::CODE_MSB:0], q.max_code);
          end
        end
        bslr_pkg::BSLR_REG_ALT: begin
          if (HAS_SETPT) begin
            d.en       = wdata_i[bslr_pkg::BIT_ENABLE];
            d.light    = wdata_i[bslr_pkg::BIT_LIGHT_LOAD];
            d.alt_code = bslr_pkg::clamp_code(wdata_i[bslr_pkg::CODE_MSB:0], q.max_code);
          end
        end
        bslr_pkg::BSLR_REG_LIMIT: begin
          if (!bslr_pkg::limit_locked(q.max_code)) begin
            d.range    = wdata_i[bslr_pkg::RANGE_MSB:bslr_pkg::RANGE_LSB];
            d.max_code = wdata_i[bslr_pkg::CODE_MSB:0];
          end
        end
        default: begin
        end
      endcase
    end
    // a reload or a reset is the only way out of the lock
    if (otp_reload_i) begin
      d = otp_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= otp_state;
    end else begin
      q <= d;
    end
  end

  assign chan_o = q;

endmodule // bslr_chan

// >>> bslr_regs.sv
`timescale 1ns/10ps
// Notes on behaviour
// - bit 7 of an operating-setpoint register reads zero, ignores writes, and hosts write zero.
// - the alternate-register enable switches its converter on only while forced-off is not active.
// - six-bit setpoint codes are turned into voltage through the same converter's range field.
// - bits 7-6 of a limit register select the converter's output range.
// - a setpoint write above a nonzero maximum code in the limit register stores that maximum instead.
// - a maximum code other than 0x3f or 0x00 locks range and maximum until defaults reload.
// - power-on reset loads programmed defaults, with reserved, select and light-load bits at zero.
// - ranges 00/01/10/11 start at 0.5/0.7/0.5/0.5 V with 12.5/12.5/25/50 mV steps.
module bslr_regs #(
  parameter int ADDR_W = 8
) (
  // clock and power-on reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // register port behind the serial control interface
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  input  wire logic [ADDR_W-1:0]         reg_addr_i,
  input  wire logic [7:0]                reg_wdata_i,
  output logic [7:0]                     reg_rdata_o,
  // programmed defaults, index 0..2 is converter two..four
  input  wire logic                      otp_reload_i,
  input  wire bslr_pkg::bslr_otp_t [2:0] otp_i,
  // converter control
  input  wire logic [2:0]                forced_off_i,
  output bslr_pkg::bslr_drive_t [2:0]    drive_o
);

  if (ADDR_W < 4) begin : g_bad_addr
    $error("bslr_regs: ADDR_W must be at least 4");
  end

  function automatic bslr_pkg::bslr_dec_t decode(input logic [ADDR_W-1:0] addr);
    bslr_pkg::bslr_dec_t r;
    r = '{hit: 1'b1, chan: 2'd0, kind: bslr_pkg::BSLR_REG_LIMIT};
    if (addr == ADDR_W'(bslr_pkg::OFF_CONV2_LIMIT)) begin
      r.chan = 2'd0;
    end else if (addr == ADDR_W'(bslr_pkg::OFF_CONV3_OP)) begin
      r = '{hit: 1'b1, chan: 2'd1, kind: bslr_pkg::BSLR_REG_OP};
    end else if (addr == ADDR_W'(bslr_pkg::OFF_CONV3_ALT)) begin
      r = '{hit: 1'b1, chan: 2'd1, kind: bslr_pkg::BSLR_REG_ALT};
    end else if (addr == ADDR_W'(bslr_pkg::OFF_CONV3_LIMIT)) begin
      r.chan = 2'd1;
    end else if (addr == ADDR_W'(bslr_pkg::OFF_CONV4_OP)) begin
      r = '{hit: 1'b1, chan: 2'd2, kind: bslr_pkg::BSLR_REG_OP};
    end else if (addr == ADDR_W'(bslr_pkg::OFF_CONV4_ALT)) begin
      r = '{hit: 1'b1, chan: 2'd2, kind: bslr_pkg::BSLR_REG_ALT};
    end else if (addr == ADDR_W'(bslr_pkg::OFF_CONV4_LIMIT)) begin
      r.chan = 2'd2;
    end else begin
      r.hit = 1'b0;
    end
    return r;
  endfunction

  function automatic logic [7:0] read_byte(input bslr_pkg::bslr_chan_t c,
                                           input bslr_pkg::bslr_reg_t k);
    unique case (k)
      bslr_pkg::BSLR_REG_OP:    return {1'b0, c.src_sel, c.op_code};
      bslr_pkg::BSLR_REG_ALT:   return {c.en, c.light, c.alt_code};
      bslr_pkg::BSLR_REG_LIMIT: return {c.range, c.max_code};
      default:                  return 8'h00;
    endcase
  endfunction

  bslr_pkg::bslr_dec_t        dec;
  bslr_pkg::bslr_chan_t [2:0] chan;
  bslr_pkg::bslr_top_t        q, d;

  assign dec = decode(reg_addr_i);

  // converter two has only its limit register in this bank
  for (genvar i = 0; i < 3; i++) begin : g_chan
    bslr_chan #(
      .HAS_SETPT (i != 0)
    ) bslr_chan_i (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .otp_reload_i (otp_reload_i),
      .otp_i        (otp_i[i]),
      .wr_i         (reg_wr_i && dec.hit && (dec.chan == 2'(i))),
      .wsel_i       (dec.kind),
      .wdata_i      (reg_wdata_i),
      .chan_o       (chan[i])
    );
  end

  always_comb begin
    logic [5:0] code;
    code = '0;
    d    = q;
    if (reg_rd_i) begin
      // unmapped offsets read as zero
      d.rdata = dec.hit ? read_byte(chan[dec.chan], dec.kind) : 8'h00;
    end
    for (int i = 0; i < 3; i++) begin
      code = chan[i].src_sel ? chan[i].alt_code : chan[i].op_code;
      d.drive[i].on    = chan[i].en && !forced_off_i[i];
      d.drive[i].light = chan[i].light;
      d.drive[i].range = chan[i].range;
      d.drive[i].code  = code;
      d.drive[i].vout  = bslr_pkg::code_to_vout(chan[i].range, code);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign drive_o     = q.drive;

endmodule // bslr_regs

// >>> bslr_properties.sv
`timescale 1ns/10ps
module bslr_properties #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  // register port
  input wire logic                        reg_wr_i,
  input wire logic                        reg_rd_i,
  input wire logic [ADDR_W-1:0]           reg_addr_i,
  input wire logic [7:0]                  reg_wdata_i,
  input wire logic [7:0]                  reg_rdata_o,
  // defaults and converter control
  input wire logic                        otp_reload_i,
  input wire bslr_pkg::bslr_otp_t [2:0]   otp_i,
  input wire logic [2:0]                  forced_off_i,
  input wire bslr_pkg::bslr_drive_t [2:0] drive_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // drive output is all zero until the first edge after reset
  sequence settled;
    !$past(rst_i) && !$past(rst_i, 2);
  endsequence
  sequence read_of(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  function automatic logic [12:0] vx(input logic [1:0] r, input logic [5:0] c);
    return 13'((r == 2'b01 ? 13'h578 : 13'h3e8) + c * (r[1] ? (r[0] ? 13'h64 : 13'h32) : 13'h19));
  endfunction
  a_reserved_bit_reads_zero: assert property (read_of(8'h0a) |=> !reg_rdata_o[7])
    else $error("reserved bit read high");
  a_forced_turns_off: assert property (forced_off_i[1] |=> !drive_o[1].on)
    else $error("converter on while forced off");
  a_enable_drives_on: assert property (settled ##0 read_of(8'h0b)
    |=> drive_o[1].on == (reg_rdata_o[7] && !$past(forced_off_i[1])))
    else $error("converter on state wrong");
  a_range_follows: assert property (settled ##0 read_of(8'h0c)
    |=> drive_o[1].range == reg_rdata_o[7:6])
    else $error("drive range differs from limit");
  a_op_source_used: assert property (settled ##0 read_of(8'h0a) ##1 !reg_rdata_o[6]
    |-> drive_o[1].code == reg_rdata_o[5:0])
    else $error("operating code not driven");
  a_vout_mapping: assert property (settled ##0 drive_o[1].on
    |-> drive_o[1].vout == vx(drive_o[1].range, drive_o[1].code))
    else $error("output voltage mapping wrong");
  a_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < 8'h09 || reg_addr_i > 8'h0f)
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
endmodule // bslr_properties

bind bslr_regs bslr_properties #(.ADDR_W(ADDR_W)) bslr_properties_i (
  .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .otp_reload_i(otp_reload_i), .otp_i(otp_i), .forced_off_i(forced_off_i), .drive_o(drive_o));

// >>> bslr_host.sv
`timescale 1ns/10ps
module bslr_host (
  // clock
  input  wire logic clk_i,
  // register port towards the device
  output logic       reg_wr_o,
  output logic       reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'hff;
    reg_wdata_o = 8'hff;
  end
  // idle bus carries the inverse so stale values never look valid
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_o <= w;
    reg_rd_o <= !w;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
    @(negedge clk_i);
  endtask
endmodule // bslr_host

// >>> buck_setpoint_limit_regs_bench.sv
`timescale 1ns/10ps
module buck_setpoint_limit_regs_bench;
  logic                        clk_i = 1'b0;
  logic                        rst_i = 1'b1;
  logic                        otp_reload_i = 1'b0;
  logic [2:0]                  forced_off_i = 3'h0;
  logic                        reg_wr_i;
  logic                        reg_rd_i;
  logic [7:0]                  reg_addr_i;
  logic [7:0]                  reg_wdata_i;
  logic [7:0]                  reg_rdata_o;
  bslr_pkg::bslr_drive_t [2:0] drive_o;
  int                          failures = 0;
  int                          compares = 0;
  int                          cycles = 0;
  int                          vexp;
  logic [7:0]                  rexp [7] = '{8'h00, 8'h20, 8'ha1, 8'hbf, 8'h05, 8'h06, 8'hf0};
  always #25 clk_i = ~clk_i;
  bslr_host bslr_host_i (.clk_i(clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
  bslr_regs bslr_regs_i (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .otp_reload_i(otp_reload_i), .forced_off_i(forced_off_i),
    .otp_i({21'h0146f0, 21'h1821bf, 21'h102200}), .drive_o(drive_o));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bslr_host_i.access(1'b0, a, 8'h00);
    check(16'(reg_rdata_o), 16'(exp), "rdata");
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bslr_host_i.access(1'b1, a, d);
  endtask
  task automatic dchk(input int k, input logic [8:0] exp);
    // look between edges so the registered drive has settled
    repeat (2) @(negedge clk_i);
    check(16'({drive_o[k].on, drive_o[k].range, drive_o[k].code}), 16'(exp), "drive");
  endtask
  task automatic end_of_test;
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) rd(8'h09 + 8'(i), rexp[i]);
    rd(8'h08, 8'h00);
    rd(8'h10, 8'h00);
    dchk(0, {1'b1, 2'b00, 6'h00});
    wr(8'h0a, 8'h7f);
    rd(8'h0a, 8'h7f);
    dchk(1, {1'b1, 2'b10, 6'h21});
    wr(8'h0a, 8'h12);
    dchk(1, {1'b1, 2'b10, 6'h12});
    for (int r = 0; r < 4; r++) begin
      wr(8'h0c, {2'(r), 6'h3f});
      dchk(1, {1'b1, 2'(r), 6'h12});
      vexp = (r == 1 ? 700 : 500) * 2 + 18 * 25 * (r < 2 ? 1 : 2 * (r - 1));
      check(16'(drive_o[1].vout), 16'(vexp), "vout");
    end
    wr(8'h0c, 8'h60);
    wr(8'h0b, 8'hbf);
    rd(8'h0b, 8'ha0);
    wr(8'h0a, 8'h3f);
    rd(8'h0a, 8'h20);
    wr(8'h0c, 8'h3f);
    rd(8'h0c, 8'h60);
    wr(8'h0f, 8'h00);
    rd(8'h0f, 8'hf0);
    dchk(2, {1'b0, 2'b11, 6'h05});
    @(posedge clk_i) otp_reload_i <= 1'b1;
    @(posedge clk_i) otp_reload_i <= 1'b0;
    rd(8'h0c, 8'hbf);
    wr(8'h0c, 8'h00);
    rd(8'h0c, 8'h00);
    @(posedge clk_i) forced_off_i <= 3'h2;
    dchk(1, {1'b0, 2'b00, 6'h20});
    @(posedge clk_i) forced_off_i <= 3'h0;
    wr(8'h0b, 8'h40);
    repeat (2) @(negedge clk_i);
    check(16'({drive_o[1].on, drive_o[1].light}), 16'h0001, "on light");
    end_of_test();
  end
endmodule // buck_setpoint_limit_regs_bench
